/* smd_assertions.sv */
// Purpose: Port-level checks of SMM routing and refusal.
// Assumes: Bound to smm_ram_decoder; ce high while checked.
// Notes: Extended checks use the always-available A/B part.
`timescale 1ns/1ps
module smd_sva import smd_pkg::*; (
  input wire logic clk_sys, rst, ce, smm_active_indication, error_clear,
  input wire smd_cfg_t cfg,
  input wire smd_req_t host_req, pci_req,
  input wire logic host_done_r, host_to_dram_r, host_cacheable_r,
  input wire logic [31:0] host_dram_addr_r, pci_dram_addr_r,
  input wire logic pci_done_r, pci_claim_r, smm_error_r
);
  wire logic [CTL_W-1:0] ctl = cfg.smm_ram_control_register;
  wire logic sm = smm_active_indication;
  wire logic hv = ce && host_req.valid;
  wire logic pv = ce && pci_req.valid;
  wire logic xon = cfg.high_memory_smm_enable && ctl[CTL_GLOBAL_EN_BIT];
  wire logic ha = host_req.addr inside {[SEG_A_BASE:SEG_B_END]};
  wire logic he = xon && host_req.addr inside {[EXT_HIGH_BASE:32'h100BFFFF]};
  wire logic pe = xon && pci_req.addr inside {[EXT_HIGH_BASE:32'h100BFFFF]};
  wire logic pc = pci_req.addr inside {[SEG_A_BASE:SEG_B_END]} &&
    ctl[CTL_BASE_MSB:CTL_BASE_LSB] == COMPAT_BASE_AB && ctl[CTL_GLOBAL_EN_BIT];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_ab_out; hv && ha && !sm |=> !host_to_dram_r; endproperty
  a_ab_out: assert property (p_ab_out) else $error("A/B reached DRAM");
  property p_ab_nc; hv && ha |=> !host_cacheable_r; endproperty
  a_ab_nc: assert property (p_ab_nc) else $error("A/B cacheable");
  property p_pci_ab; pv && pc |=> pci_done_r && !pci_claim_r; endproperty
  a_pci_ab: assert property (p_pci_ab) else $error("A/B claimed");
  property p_pci_ext; pv && pe |=> !pci_claim_r; endproperty
  a_pci_ext: assert property (p_pci_ext) else $error("Ext claimed");
  property p_err; hv && he && !sm && !ctl[CTL_OPEN_BIT] &&
    !host_req.modified_write |=> smm_error_r && !host_to_dram_r; endproperty
  a_err: assert property (p_err) else $error("No error on denial");
  property p_xlate; hv && he && sm |=> host_to_dram_r && host_cacheable_r &&
    host_dram_addr_r == ($past(host_req.addr) & EXT_TO_DRAM_MASK); endproperty
  a_xlate: assert property (p_xlate) else $error("Bad translation");
  property p_mw; hv && he && host_req.modified_write |=> host_to_dram_r;
  endproperty
  a_mw: assert property (p_mw) else $error("Modified write refused");
  property p_sticky; smm_error_r && !error_clear |=> smm_error_r; endproperty
  a_sticky: assert property (p_sticky) else $error("Error flag lost");
  c_err: cover property (hv && he && !sm);
  c_pci: cover property (pv && pc);
  c_mw: cover property (hv && he && host_req.modified_write);
endmodule : smd_sva

/* smd_master_model.sv */
// Purpose: Host and PCI master stand-in driving request structs.
// Assumes: Launch at falling edge, taken at the next rising edge.
// Notes: Released lines show inverted values, never stale ones.
`timescale 1ns/1ps
module smd_master_model import smd_pkg::*; (
  input wire logic clk_sys,
  output smd_req_t host_req,
  output smd_req_t pci_req
);
  initial begin
    host_req = '0;
    pci_req = '0;
  end
  task automatic host(input logic [31:0] a, input logic cf, input logic mw);
    @(negedge clk_sys);
    host_req = '{1'b1, a, cf, mw};
    @(negedge clk_sys);
    host_req = '{1'b0, ~a, ~cf, ~mw};
  endtask : host
  task automatic pci(input logic [31:0] a);
    @(negedge clk_sys);
    pci_req = '{1'b1, a, 1'b0, 1'b0};
    @(negedge clk_sys);
    pci_req = '{1'b0, ~a, 1'b1, 1'b1};
  endtask : pci
endmodule : smd_master_model

/* smd_pkg.sv */
// Purpose: Shared constants and types for the SMM RAM decoder.
// Assumes: 32-bit host and PCI addresses, byte granular.
// Notes: Control field positions index the 7-bit SMM RAM control word.
package smd_pkg;

  // SMM RAM control register, low seven bits
  localparam int CTL_W = 7;
  localparam int CTL_OPEN_BIT = 6;
  localparam int CTL_CLOSE_BIT = 5;
  localparam int CTL_GLOBAL_EN_BIT = 3;
  localparam int CTL_BASE_MSB = 2;
  localparam int CTL_BASE_LSB = 0;
  localparam logic [2:0] COMPAT_BASE_AB = 3'h2;
  localparam logic [CTL_W-1:0] CTL_RESET = 7'h02;

  // Legacy segments below 1 Mbyte
  localparam logic [31:0] SEG_A_BASE = 32'h000A0000;
  localparam logic [31:0] SEG_B_END = 32'h000BFFFF;
  localparam logic [31:0] SEG_C_BASE = 32'h000C0000;
  localparam logic [31:0] SEG_F_END = 32'h000FFFFF;

  // Extended high-memory window and its DRAM alias
  localparam logic [31:0] EXT_HIGH_BASE = 32'h100A0000;
  localparam logic [31:0] EXT_HIGH_END = 32'h100FFFFF;
  localparam logic [31:0] EXT_TOP_SMM_SEGMENT_OFFSET = 32'h10000000;
  localparam logic [31:0] EXT_TO_DRAM_MASK = 32'h0FFFFFFF;

  // Top segment sizes, 128 Kbyte shifted left by the size field
  localparam logic [31:0] TOP_SMM_SEGMENT_UNIT = 32'h00020000;

  // Segment index inside the C..F attribute vectors
  localparam int SEG_F_IDX = 3;
  localparam int SEG_IDX_LSB = 16;

  typedef struct packed {
    logic [CTL_W-1:0] smm_ram_control_register;
    logic high_memory_smm_enable;
    logic top_segment_enable;
    logic [1:0] top_segment_size_field;
    logic [31:0] top_of_memory;
    logic [3:0] shadow_seg;   // C,D,E,F given to shadowing
    logic f_suspend_resume;   // F segment marked for suspend/resume
  } smd_cfg_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic code_fetch;
    logic modified_write;
  } smd_req_t;

  typedef struct packed {
    logic compat_ab;      // A/B segment, any use
    logic compat_on;      // Compatible region enabled
    logic ext_hit;        // Enabled extended region hit
    logic legacy_shadow;  // C..F shadowed to DRAM
    logic below_tom;      // Ordinary main memory
    logic [31:0] dram_addr;
  } smd_hit_t;

  function automatic logic [31:0] top_smm_segment_bytes(input logic [1:0] sz);
    top_smm_segment_bytes = TOP_SMM_SEGMENT_UNIT << sz;
  endfunction : top_smm_segment_bytes

endpackage : smd_pkg

/* smd_region_decode.sv */
// Purpose: Combinational region decode of one address against SMM map.
// Assumes: Configuration is stable while requests are in flight.
// Notes: Used once for host requests and once for PCI requests.
`timescale 1ns/1ps
module smd_region_decode import smd_pkg::*; (
  input wire smd_cfg_t cfg,
  input wire logic [31:0] addr,
  output smd_hit_t hit
);

  wire logic [CTL_W-1:0] ctl = cfg.smm_ram_control_register;
  wire logic g_en = ctl[CTL_GLOBAL_EN_BIT];
  wire logic ext_en = g_en && cfg.high_memory_smm_enable;
  wire logic top_smm_segment_on = g_en && cfg.top_segment_enable;
  wire logic [31:0] tsz = top_smm_segment_bytes(cfg.top_segment_size_field);
  // Top block is cut from normal memory only while enabled
  wire logic [31:0] main_top = top_smm_segment_on ? cfg.top_of_memory - tsz
                                       : cfg.top_of_memory;
  wire logic [31:0] top_smm_segment_lo = EXT_TOP_SMM_SEGMENT_OFFSET + main_top;
  wire logic [31:0] top_smm_segment_hi = EXT_TOP_SMM_SEGMENT_OFFSET + cfg.top_of_memory;

  wire logic in_ab = addr >= SEG_A_BASE && addr <= SEG_B_END;
  wire logic in_cf = addr >= SEG_C_BASE && addr <= SEG_F_END;
  wire logic in_high = addr >= EXT_HIGH_BASE && addr <= EXT_HIGH_END;
  wire logic in_top_smm_segment = top_smm_segment_on && addr >= top_smm_segment_lo && addr < top_smm_segment_hi;
  wire logic [1:0] seg_idx = addr[SEG_IDX_LSB+1:SEG_IDX_LSB];
  wire logic high_ab = in_high && addr <= (SEG_B_END | EXT_TOP_SMM_SEGMENT_OFFSET);
  // C..E only when not shadowed, F only for suspend/resume
  wire logic high_cf_ok = (seg_idx == 2'(SEG_F_IDX)) ? cfg.f_suspend_resume
                                                     : !cfg.shadow_seg[seg_idx];
  wire logic high_ok = ext_en && in_high && (high_ab || high_cf_ok);

  assign hit.compat_ab = in_ab;
  assign hit.compat_on = g_en && ctl[CTL_BASE_MSB:CTL_BASE_LSB] == COMPAT_BASE_AB;
  assign hit.ext_hit = high_ok || in_top_smm_segment;
  assign hit.legacy_shadow = in_cf && cfg.shadow_seg[seg_idx];
  assign hit.below_tom = addr < main_top && !in_ab && !in_cf;
  // Strip the 256 Mbyte offset to reach the DRAM alias
  assign hit.dram_addr = addr & EXT_TO_DRAM_MASK;

endmodule : smd_region_decode

/* smd_tb.sv */
// Purpose: Self-checking bench for the SMM RAM decoder.
// Assumes: One idle cycle between requests; ce low only in freeze test.
// Notes: Top of memory fixed at 64 Mbyte to keep windows apart.
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  miscompares++; $display("Error %s exp %0h got %0h", n, e, g); end end
module tb import smd_pkg::*;;
  logic clk_sys = 0, rst = 1, ce = 1, error_clear = 0;
  logic smm_active_indication = 0;
  smd_cfg_t cfg = '0;
  smd_req_t host_req, pci_req;
  logic host_done_r, host_to_dram_r, host_cacheable_r, pci_done_r;
  logic pci_claim_r, smm_error_r;
  logic [31:0] host_dram_addr_r, pci_dram_addr_r;
  int miscompares = 0, tests_run = 0, cyc = 0;
  localparam logic [31:0] TOP_OF_MEMORY = 32'h04000000;
  smm_ram_decoder dut(.*);
  smd_master_model mdl(.*);
  initial forever #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 1000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic t_compat();
    cfg.smm_ram_control_register = 7'h0A;
    mdl.host(SEG_A_BASE, 0, 0);
    `CHK("ab out", 2'b10, {host_done_r, host_to_dram_r})
    smm_active_indication = 1;
    mdl.host(SEG_B_END, 0, 0);
    `CHK("ab smm", 2'b10, {host_to_dram_r, host_cacheable_r})
    cfg.smm_ram_control_register = 7'h2A;
    mdl.host(SEG_A_BASE, 0, 0);
    `CHK("ab close", 1'b0, host_to_dram_r)
    mdl.host(SEG_A_BASE, 1, 0);
    `CHK("ab fetch", 1'b1, host_to_dram_r)
    mdl.pci(SEG_A_BASE);
    `CHK("pci ab", 2'b10, {pci_done_r, pci_claim_r})
    $display("compat test done");
  endtask : t_compat
  task automatic t_ext();
    cfg.smm_ram_control_register = 7'h08;
    cfg.high_memory_smm_enable = 1;
    cfg.top_of_memory = TOP_OF_MEMORY;
    mdl.host(32'h100A1234, 0, 0);
    `CHK("ext addr", 32'h000A1234, host_dram_addr_r)
    `CHK("ext cache", 2'b11, {host_to_dram_r, host_cacheable_r})
    smm_active_indication = 0;
    mdl.host(32'h100B0000, 0, 0);
    `CHK("ext deny", 2'b01, {host_to_dram_r, smm_error_r})
    error_clear = 1;
    @(negedge clk_sys);
    error_clear = 0;
    `CHK("err clear", 1'b0, smm_error_r)
    mdl.host(32'h100B0000, 0, 1);
    `CHK("mod write", 2'b10, {host_to_dram_r, smm_error_r})
    cfg.shadow_seg = 4'h1;
    mdl.host(32'h100C0000, 0, 0);
    `CHK("shadowed", 2'b00, {host_to_dram_r, smm_error_r})
    cfg.smm_ram_control_register = 7'h48;
    mdl.host(32'h100D0000, 0, 0);
    `CHK("open", 1'b1, host_to_dram_r)
    mdl.pci(32'h100A0000);
    `CHK("pci ext", 1'b0, pci_claim_r)
    cfg.f_suspend_resume = 1;
    smm_active_indication = 1;
    mdl.host(32'h100F0000, 0, 0);
    `CHK("f seg", 1'b1, host_to_dram_r)
    $display("extended test done");
  endtask : t_ext
  task automatic t_top_smm_segment();
    logic [31:0] sz;
    cfg.top_segment_enable = 1;
    for (int i = 0; i < 4; i++) begin
      sz = 32'h00020000 << i;
      cfg.top_segment_size_field = i[1:0];
      mdl.host(32'h10000000 + TOP_OF_MEMORY - sz, 0, 0);
      `CHK("top_smm_segment addr", TOP_OF_MEMORY - sz, host_dram_addr_r)
      `CHK("top_smm_segment dram", 1'b1, host_to_dram_r)
      mdl.host(TOP_OF_MEMORY - sz, 0, 0);
      `CHK("top_smm_segment cut", 1'b0, host_to_dram_r)
      mdl.pci(TOP_OF_MEMORY - sz - 1);
      `CHK("pci below", 1'b1, pci_claim_r)
    end
    cfg.smm_ram_control_register = 7'h00;
    mdl.host(32'h10000000 + TOP_OF_MEMORY - 1, 0, 0);
    `CHK("no global", 1'b0, host_to_dram_r)
    $display("top segment test done");
  endtask : t_top_smm_segment
  task automatic t_misc();
    mdl.pci(32'h00012340);
    `CHK("pci addr", 32'h00012340, pci_dram_addr_r)
    `CHK("pci plain", 1'b1, pci_claim_r)
    // Frozen clock enable must leave the last route untouched
    ce = 0;
    mdl.host(32'h00012340, 0, 0);
    `CHK("ce hold", 32'h13FFFFFF, host_dram_addr_r)
    ce = 1;
    cfg.smm_ram_control_register = 7'h08;
    smm_active_indication = 0;
    error_clear = 1;
    mdl.host(32'h100A0000, 0, 0);
    error_clear = 0;
    `CHK("set beats clear", 1'b1, smm_error_r)
    rst = 1;
    @(negedge clk_sys);
    rst = 0;
    `CHK("reset err", 1'b0, smm_error_r)
    `CHK("reset addr", 32'h00000000, host_dram_addr_r)
    $display("misc test done");
  endtask : t_misc
  initial begin
    repeat (10) @(negedge clk_sys);
    rst = 0;
    t_compat();
    t_ext();
    t_top_smm_segment();
    t_misc();
    test_done();
  end
endmodule : tb
bind smm_ram_decoder smd_sva u_sva(.*);

/* smm_ram_decoder.sv */
// Purpose: Routes host and PCI memory cycles around SMM storage.
// Assumes: One request per side per cycle, answered on the next edge.
// Notes: Error flag is sticky; its set beats a simultaneous clear.
// How it works
// - Base field 010 with global enable reserves A/B segments as SMM RAM.
// - Outside SMM, host A/B accesses go to PCI, never DRAM.
// - Inside SMM, A/B routing follows control bits: close blocks data use.
// - PCI cycles to SMM storage are not claimed, no device select.
// - Unauthorised extended access sets the error flag and goes to PCI.
// - Extended mode gives up to 1 Mbyte writeback-cacheable SMM storage.
// - Top segment is 128K, 256K, 512K or 1M by two-bit size field.
// - Enabled top segment is cut from the top of normal memory.
// - Host 100A0000h-100FFFFFh maps to DRAM 000A0000h-000FFFFFh.
// - Host 10000000h plus top segment window maps to DRAM below top.
// - A and B give 64K each when high and global enables are set.
// - C, D, E serve only when not shadowed and both enables set.
// - F serves only when marked suspend/resume and both enables set.
// - Top segment serves only with its own enable and global enable.
// - PCI master accesses to extended ranges are never claimed.
// - Modified-line host writes enter enabled extended SMM space regardless of SMM and open bit.
`timescale 1ns/1ps
module smm_ram_decoder import smd_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire smd_cfg_t cfg,
  input wire logic smm_active_indication,
  input wire smd_req_t host_req,
  input wire smd_req_t pci_req,
  input wire logic error_clear,
  output logic host_done_r,
  output logic host_to_dram_r,
  output logic host_cacheable_r,
  output logic [31:0] host_dram_addr_r,
  output logic pci_done_r,
  output logic pci_claim_r,
  output logic [31:0] pci_dram_addr_r,
  output logic smm_error_r
);

  smd_hit_t hh;
  smd_hit_t ph;

  smd_region_decode u_host_dec (
    .cfg(cfg),
    .addr(host_req.addr),
    .hit(hh)
  );

  smd_region_decode u_pci_dec (
    .cfg(cfg),
    .addr(pci_req.addr),
    .hit(ph)
  );

  wire logic [CTL_W-1:0] ctl = cfg.smm_ram_control_register;
  wire logic open_bit = ctl[CTL_OPEN_BIT];
  wire logic close_bit = ctl[CTL_CLOSE_BIT];
  wire logic smm = smm_active_indication;

  // Compatible A/B region
  wire logic h_compat = hh.compat_on && hh.compat_ab;
  // Close bit keeps data away from SMM RAM, code fetches still reach it
  wire logic h_compat_dram = smm && !(close_bit && !host_req.code_fetch);
  // Extended regions: SMM, open bit or modified-line write unlock them
  wire logic h_ext_ok = smm || open_bit || host_req.modified_write;
  wire logic h_ext_bad = hh.ext_hit && !h_ext_ok;

  // Ordinary decode, main memory ending below an enabled top segment
  wire logic h_plain_dram = hh.below_tom || hh.legacy_shadow;

  logic h_dram_nxt;
  logic h_cache_nxt;
  always_comb begin
    h_dram_nxt = h_plain_dram;
    h_cache_nxt = h_plain_dram;
    if (h_compat) begin
      // Outside SMM A/B never reaches DRAM; inside it is noncacheable
      h_dram_nxt = h_compat_dram;
      h_cache_nxt = 1'b0;
    end else if (hh.compat_ab) begin
      h_dram_nxt = 1'b0;
      h_cache_nxt = 1'b0;
    end else if (hh.ext_hit) begin
      h_dram_nxt = h_ext_ok;
      h_cache_nxt = h_ext_ok;
    end
  end

  // Host address to DRAM: extended hits drop the 256 Mbyte offset
  wire logic [31:0] h_addr_nxt = hh.ext_hit ? hh.dram_addr
                                            : host_req.addr;

  // PCI masters may touch no SMM storage at all
  wire logic p_smm = (ph.compat_on && ph.compat_ab) || ph.ext_hit;
  wire logic p_claim_nxt = !p_smm && (ph.below_tom || ph.legacy_shadow);

  // Error flag: set wins when clear arrives in the same cycle
  wire logic err_set = host_req.valid && h_ext_bad;
  wire logic err_nxt = err_set || (smm_error_r && !error_clear);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      host_done_r <= 1'b0;
      host_to_dram_r <= 1'b0;
      host_cacheable_r <= 1'b0;
      host_dram_addr_r <= 32'h00000000;
    end else if (ce) begin
      host_done_r <= host_req.valid;
      if (host_req.valid) begin
        host_to_dram_r <= h_dram_nxt;
        host_cacheable_r <= h_cache_nxt;
        host_dram_addr_r <= h_addr_nxt;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pci_done_r <= 1'b0;
      pci_claim_r <= 1'b0;
      pci_dram_addr_r <= 32'h00000000;
    end else if (ce) begin
      pci_done_r <= pci_req.valid;
      pci_claim_r <= pci_req.valid && p_claim_nxt;
      if (pci_req.valid) begin
        pci_dram_addr_r <= pci_req.addr;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      smm_error_r <= 1'b0;
    end else if (ce) begin
      smm_error_r <= err_nxt;
    end
  end

endmodule : smm_ram_decoder
